// ==== rtl/rscf_pkg.sv ====
// shared constants and checksum function of the serial command framer
// assumes both ends are compiled against this package
`default_nettype none
package rscf_pkg;
   localparam logic [7:0]  SOF         = 8'hff;
   localparam logic [7:0]  REQ_MAX     = 8'hfa;
   localparam logic [7:0]  RSP_MAX     = 8'hf8;
   localparam logic [15:0] CRC_POLY    = 16'h1021;
   localparam logic [15:0] CRC_SEED    = 16'hffff;
   localparam logic [15:0] ST_OK       = 16'h0000;
   localparam logic [15:0] ST_CRC_ERR  = 16'h0100;
   localparam logic [15:0] ST_BOOT_ERR = 16'h0101;
   localparam logic [7:0]  B_ONE       = 8'h01;
   localparam logic [1:0]  F_ONE       = 2'h1;
   localparam logic [1:0]  F_FULL      = 2'h2;
   localparam int          MEM_DEPTH   = 256;

   // one byte into a ccitt crc, msb first
   function automatic logic [15:0] rscf_crc(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ==== rtl/rscf_link_if.sv ====
// byte link between host end and device end, one byte stream each way
// assumes the bench joins both ends on one clock
`default_nettype none
interface rscf_link_if;
   logic       enable;
   logic [7:0] h2d_data;
   logic       h2d_valid;
   logic       h2d_ready;
   logic [7:0] d2h_data;
   logic       d2h_valid;
   logic       d2h_ready;
   modport dev  (input enable, h2d_data, h2d_valid, d2h_ready,
                 output h2d_ready, d2h_data, d2h_valid);
   modport host (output enable, h2d_data, h2d_valid, d2h_ready,
                 input h2d_ready, d2h_data, d2h_valid);
endinterface
`default_nettype wire

// ==== rtl/rscf_device.sv ====
// device end: boot image check, request parser, response framer
// assumes img_data answers img_addr within the same cycle (async rom)
// Function
// - host waits for response before next request
// - device only answers, never starts
// - one command at a time, in order
// - request: marker, length, opcode, payload, checksum
// - response adds status word, payload up to 248
// - same ccitt crc both directions
// - crc covers length, opcode, status, payload
// - start marker excluded from crc
// - host owns timeouts and retries
// - boot check runs after reset, then application
// - recompute image crc, compare to stored
// - bad image: stay in loader, report error
// - return to loader transparently, no pin; here the boot_req input requests it
// - enable active high, defaults enabled
// - host holds rx low while off
`default_nettype none
module rscf_device
   import rscf_pkg::*;
#(
   parameter int AW = 16,
   parameter logic [AW-1:0] IMG_LAST = 16'h00ff
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // link
   rscf_link_if.dev           link,
   // image rom
   output logic [AW-1:0]      img_addr,
   input  wire logic [7:0]    img_data,
   input  wire logic [15:0]   img_crc,
   // mode
   input  wire logic          boot_req,
   output logic               app_run,
   output logic               boot_err,
   // command to application
   output logic               cmd_valid,
   output logic [7:0]         cmd_op,
   output logic [7:0]         cmd_len,
   input  wire logic [7:0]    cmd_rd_addr,
   output logic [7:0]         cmd_rd_data,
   // response from application
   input  wire logic          resp_valid,
   input  wire logic [15:0]   resp_status,
   input  wire logic [7:0]    resp_len,
   input  wire logic          resp_wr_en,
   input  wire logic [7:0]    resp_wr_addr,
   input  wire logic [7:0]    resp_wr_data
);
   import rscf_pkg::*;

   typedef enum logic [1:0] {B_SCAN = 2'h0, B_APP = 2'h1, B_LDR = 2'h2,
                             B_FAIL = 2'h3} rscf_bst_t;
   typedef enum logic [3:0] {P_HDR = 4'h0, P_LEN = 4'h1, P_CMD = 4'h2, P_DATA = 4'h3,
                             P_CKH = 4'h4, P_CKL = 4'h5, P_EXEC = 4'h6, P_WAIT = 4'h7,
                             T_HDR = 4'h8, T_LEN = 4'h9, T_CMD = 4'ha, T_STH = 4'hb,
                             T_STL = 4'hc, T_DATA = 4'hd, T_CKH = 4'he,
                             T_CKL = 4'hf} rscf_pst_t;

   rscf_bst_t     bst_r, bst_nxt;
   rscf_pst_t     pst_r, pst_nxt;
   logic [AW-1:0] ia_r, ia_nxt;
   logic [15:0]   ic_r, ic_nxt, crc_r, crc_nxt, st_r, st_nxt;
   logic [7:0]    len_r, len_nxt, op_r, op_nxt, idx_r, idx_nxt, ckh_r, ckh_nxt;
   logic          ok_r, ok_nxt, rdy_r, rdy_nxt, cv_r, cv_nxt;
   logic [7:0]    f0_r, f0_nxt, f1_r, f1_nxt;
   logic [1:0]    cnt_r, cnt_nxt;
   logic          vld_r, vld_nxt, app_r, err_r;
   logic [7:0]    crd_r;
   logic [7:0]    rxm [0:MEM_DEPTH-1];
   logic [7:0]    txm [0:MEM_DEPTH-1];
   logic          take, push, pop, rx_we;
   logic [15:0]   ic_step;
   logic [7:0]    pb;

   always_comb begin
      bst_nxt = bst_r;
      pst_nxt = pst_r;
      ia_nxt = ia_r;
      ic_nxt = ic_r;
      crc_nxt = crc_r;
      st_nxt = st_r;
      len_nxt = len_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      ckh_nxt = ckh_r;
      ok_nxt = ok_r;
      cv_nxt = 1'b0;
      push = 1'b0;
      pb = 8'h00;
      rx_we = 1'b0;
      take = link.h2d_valid && rdy_r;
      pop = vld_r && link.d2h_ready;
      ic_step = rscf_crc(ic_r, img_data);
      // boot loader: walk the image after every reset or on leaving the loader
      case (bst_r)
         B_SCAN: begin
            ic_nxt = ic_step;
            ia_nxt = ia_r + 1'b1;
            if (ia_r == IMG_LAST) begin
               bst_nxt = (ic_step == img_crc) ? B_APP : B_FAIL;
            end
         end
         B_APP: if (boot_req) bst_nxt = B_LDR;
         B_LDR: if (!boot_req) begin
            bst_nxt = B_SCAN;
            ia_nxt = '0;
            ic_nxt = CRC_SEED;
         end
         default: ;
      endcase
      // receive side only moves on host bytes, transmit only after a request
      case (pst_r)
         P_HDR: if (take && link.h2d_data == SOF) begin
            pst_nxt = P_LEN;
            crc_nxt = CRC_SEED;
         end
         P_LEN: if (take) begin
            len_nxt = link.h2d_data;
            crc_nxt = rscf_crc(crc_r, link.h2d_data);
            // overlong request cannot be framed: drop and resync
            pst_nxt = (link.h2d_data > REQ_MAX) ? P_HDR : P_CMD;
         end
         P_CMD: if (take) begin
            op_nxt = link.h2d_data;
            crc_nxt = rscf_crc(crc_r, link.h2d_data);
            idx_nxt = '0;
            pst_nxt = (len_r == '0) ? P_CKH : P_DATA;
         end
         P_DATA: if (take) begin
            rx_we = 1'b1;
            crc_nxt = rscf_crc(crc_r, link.h2d_data);
            idx_nxt = idx_r + B_ONE;
            if (idx_r + B_ONE == len_r) pst_nxt = P_CKH;
         end
         P_CKH: if (take) begin
            ckh_nxt = link.h2d_data;
            pst_nxt = P_CKL;
         end
         P_CKL: if (take) begin
            ok_nxt = ({ckh_r, link.h2d_data} == crc_r);
            pst_nxt = P_EXEC;
         end
         P_EXEC: begin
            if (!ok_r) begin
               st_nxt = ST_CRC_ERR;
               len_nxt = '0;
               pst_nxt = T_HDR;
            end else if (bst_r == B_FAIL) begin
               st_nxt = ST_BOOT_ERR;
               len_nxt = '0;
               pst_nxt = T_HDR;
            end else begin
               cv_nxt = 1'b1;
               pst_nxt = P_WAIT;
            end
         end
         P_WAIT: if (resp_valid) begin
            st_nxt = resp_status;
            len_nxt = (resp_len > RSP_MAX) ? RSP_MAX : resp_len;
            pst_nxt = T_HDR;
         end
         default: if (cnt_r != F_FULL) begin
            // fifo room stalls the framer, so a slow host loses no byte
            push = 1'b1;
            case (pst_r)
               T_HDR: begin
                  pb = SOF;
                  crc_nxt = CRC_SEED;
                  pst_nxt = T_LEN;
               end
               T_LEN: begin
                  pb = len_r;
                  pst_nxt = T_CMD;
               end
               T_CMD: begin
                  pb = op_r;
                  pst_nxt = T_STH;
               end
               T_STH: begin
                  pb = st_r[15:8];
                  pst_nxt = T_STL;
               end
               T_STL: begin
                  pb = st_r[7:0];
                  idx_nxt = '0;
                  pst_nxt = (len_r == '0) ? T_CKH : T_DATA;
               end
               T_DATA: begin
                  pb = txm[idx_r];
                  idx_nxt = idx_r + B_ONE;
                  if (idx_r + B_ONE == len_r) pst_nxt = T_CKH;
               end
               T_CKH: begin
                  pb = crc_r[15:8];
                  pst_nxt = T_CKL;
               end
               default: begin
                  pb = crc_r[7:0];
                  pst_nxt = P_HDR;
               end
            endcase
            if (pst_r != T_HDR && pst_r != T_CKH && pst_r != T_CKL) begin
               crc_nxt = rscf_crc(crc_r, pb);
            end
         end
      endcase
      // two-entry buffer, head is the link output
      f0_nxt = f0_r;
      f1_nxt = f1_r;
      cnt_nxt = cnt_r;
      if (pop && push) begin
         if (cnt_r == F_ONE) begin
            f0_nxt = pb;
         end else begin
            f0_nxt = f1_r;
            f1_nxt = pb;
         end
      end else if (pop) begin
         f0_nxt = f1_r;
         cnt_nxt = cnt_r - F_ONE;
      end else if (push) begin
         if (cnt_r == '0) f0_nxt = pb;
         else f1_nxt = pb;
         cnt_nxt = cnt_r + F_ONE;
      end
      // off: drop protocol state, rerun the boot check on enable
      if (!link.enable) begin
         pst_nxt = P_HDR;
         cnt_nxt = '0;
         cv_nxt = 1'b0;
         bst_nxt = B_SCAN;
         ia_nxt = '0;
         ic_nxt = CRC_SEED;
      end
      vld_nxt = (cnt_nxt != '0);
      rdy_nxt = (pst_nxt <= P_CKL) && (bst_nxt != B_SCAN) && link.enable;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bst_r <= B_SCAN;
         pst_r <= P_HDR;
         ia_r <= '0;
         ic_r <= CRC_SEED;
         crc_r <= CRC_SEED;
         st_r <= ST_OK;
         len_r <= '0;
         op_r <= '0;
         idx_r <= '0;
         ckh_r <= '0;
         ok_r <= 1'b0;
         cv_r <= 1'b0;
         rdy_r <= 1'b0;
         f0_r <= '0;
         f1_r <= '0;
         cnt_r <= '0;
         vld_r <= 1'b0;
         app_r <= 1'b0;
         err_r <= 1'b0;
         crd_r <= '0;
      end else if (ce) begin
         bst_r <= bst_nxt;
         pst_r <= pst_nxt;
         ia_r <= ia_nxt;
         ic_r <= ic_nxt;
         crc_r <= crc_nxt;
         st_r <= st_nxt;
         len_r <= len_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         ckh_r <= ckh_nxt;
         ok_r <= ok_nxt;
         cv_r <= cv_nxt;
         rdy_r <= rdy_nxt;
         f0_r <= f0_nxt;
         f1_r <= f1_nxt;
         cnt_r <= cnt_nxt;
         vld_r <= vld_nxt;
         app_r <= (bst_nxt == B_APP);
         err_r <= (bst_nxt == B_FAIL);
         crd_r <= rxm[cmd_rd_addr];
      end
   end

   // payload memories, no reset
   always_ff @(posedge clk) begin
      if (ce && rx_we) rxm[idx_r] <= link.h2d_data;
      if (ce && resp_wr_en) txm[resp_wr_addr] <= resp_wr_data;
   end

   assign link.h2d_ready = rdy_r;
   assign link.d2h_valid = vld_r;
   assign link.d2h_data  = f0_r;
   assign img_addr       = ia_r;
   assign app_run        = app_r;
   assign boot_err       = err_r;
   assign cmd_valid      = cv_r;
   assign cmd_op         = op_r;
   assign cmd_len        = len_r;
   assign cmd_rd_data    = crd_r;
endmodule
`default_nettype wire

// ==== rtl/rscf_host.sv ====
// host end: sends one request, collects its response or times out
// assumes the device end sits on the same clock across the link interface
`default_nettype none
module rscf_host
   import rscf_pkg::*;
#(
   parameter int TW = 24
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // link
   rscf_link_if.host          link,
   // control
   input  wire logic          en_in,
   input  wire logic          rx_hold,
   input  wire logic [TW-1:0] tmo_cycles,
   // request
   input  wire logic          req_valid,
   input  wire logic [7:0]    req_op,
   input  wire logic [7:0]    req_len,
   input  wire logic          req_wr_en,
   input  wire logic [7:0]    req_wr_addr,
   input  wire logic [7:0]    req_wr_data,
   output logic               busy,
   // response
   output logic               rsp_valid,
   output logic               rsp_timeout,
   output logic               rsp_crc_ok,
   output logic [7:0]         rsp_op,
   output logic [15:0]        rsp_status,
   output logic [7:0]         rsp_len,
   input  wire logic [7:0]    rsp_rd_addr,
   output logic [7:0]         rsp_rd_data
);
   import rscf_pkg::*;

   typedef enum logic [3:0] {H_IDLE = 4'h0, H_HDR = 4'h1, H_LEN = 4'h2, H_CMD = 4'h3,
                             H_DATA = 4'h4, H_CKH = 4'h5, H_CKL = 4'h6, H_DRN = 4'h7,
                             R_HDR = 4'h8, R_LEN = 4'h9, R_CMD = 4'ha, R_STH = 4'hb,
                             R_STL = 4'hc, R_DATA = 4'hd, R_CKH = 4'he,
                             R_CKL = 4'hf} rscf_hst_t;

   rscf_hst_t     s_r, s_nxt;
   logic [7:0]    hd_r, hd_nxt, len_r, len_nxt, op_r, op_nxt, idx_r, idx_nxt, ckh_r, ckh_nxt;
   logic [15:0]   crc_r, crc_nxt, st_r, st_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic          hv_r, hv_nxt, dr_r, dr_nxt, en_r, rv_r, rv_nxt, to_r, to_nxt, ok_r, ok_nxt;
   logic [7:0]    rd_r;
   logic [7:0]    txm [0:MEM_DEPTH-1];
   logic [7:0]    rxm [0:MEM_DEPTH-1];
   logic          ld, take, rx_we, busy_r;
   logic [7:0]    pb;

   always_comb begin
      s_nxt = s_r;
      hd_nxt = hd_r;
      hv_nxt = hv_r;
      len_nxt = len_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      ckh_nxt = ckh_r;
      crc_nxt = crc_r;
      st_nxt = st_r;
      ok_nxt = ok_r;
      rv_nxt = 1'b0;
      to_nxt = 1'b0;
      rx_we = 1'b0;
      pb = 8'h00;
      tmr_nxt = (s_r >= R_HDR) ? tmr_r + 1'b1 : '0;
      ld = !hv_r || link.h2d_ready;
      take = link.d2h_valid && dr_r;
      case (s_r)
         H_IDLE: if (req_valid && en_r) begin
            op_nxt = req_op;
            len_nxt = (req_len > REQ_MAX) ? REQ_MAX : req_len;
            s_nxt = H_HDR;
         end
         H_DRN: if (link.h2d_ready) begin
            hv_nxt = 1'b0;
            s_nxt = R_HDR;
         end
         R_HDR: if (take && link.d2h_data == SOF) begin
            crc_nxt = CRC_SEED;
            s_nxt = R_LEN;
         end
         R_LEN, R_CMD, R_STH, R_STL, R_DATA: if (take) begin
            crc_nxt = rscf_crc(crc_r, link.d2h_data);
            s_nxt = rscf_hst_t'(s_r + 1'b1);
            case (s_r)
               R_LEN: len_nxt = link.d2h_data;
               R_CMD: op_nxt = link.d2h_data;
               R_STH: st_nxt[15:8] = link.d2h_data;
               R_STL: begin
                  st_nxt[7:0] = link.d2h_data;
                  idx_nxt = '0;
                  if (len_r == '0) s_nxt = R_CKH;
               end
               default: begin
                  rx_we = 1'b1;
                  idx_nxt = idx_r + B_ONE;
                  s_nxt = (idx_r + B_ONE == len_r) ? R_CKH : R_DATA;
               end
            endcase
         end
         R_CKH: if (take) begin
            ckh_nxt = link.d2h_data;
            s_nxt = R_CKL;
         end
         R_CKL: if (take) begin
            ok_nxt = ({ckh_r, link.d2h_data} == crc_r);
            rv_nxt = 1'b1;
            s_nxt = H_IDLE;
         end
         default: if (ld) begin
            hv_nxt = 1'b1;
            s_nxt = rscf_hst_t'(s_r + 1'b1);
            case (s_r)
               H_HDR: pb = SOF;
               H_LEN: pb = len_r;
               H_CMD: begin
                  pb = op_r;
                  idx_nxt = '0;
                  if (len_r == '0) s_nxt = H_CKH;
               end
               H_DATA: begin
                  pb = txm[idx_r];
                  idx_nxt = idx_r + B_ONE;
                  s_nxt = (idx_r + B_ONE == len_r) ? H_CKH : H_DATA;
               end
               H_CKH: pb = crc_r[15:8];
               default: pb = crc_r[7:0];
            endcase
            hd_nxt = pb;
            if (s_r == H_HDR) crc_nxt = CRC_SEED;
            else if (s_r != H_CKH && s_r != H_CKL) crc_nxt = rscf_crc(crc_r, pb);
         end
      endcase
      // the host alone owns the per-command deadline and any retry
      if (s_r >= R_HDR && tmr_r == tmo_cycles) begin
         to_nxt = 1'b1;
         s_nxt = H_IDLE;
      end
      // module off: rx line held low
      if (!en_r) begin
         s_nxt = H_IDLE;
         hv_nxt = 1'b0;
         hd_nxt = '0;
      end
      dr_nxt = (s_nxt >= R_HDR) && !rx_hold;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= H_IDLE;
         hd_r <= '0;
         hv_r <= 1'b0;
         len_r <= '0;
         op_r <= '0;
         idx_r <= '0;
         ckh_r <= '0;
         crc_r <= CRC_SEED;
         st_r <= ST_OK;
         ok_r <= 1'b0;
         rv_r <= 1'b0;
         to_r <= 1'b0;
         tmr_r <= '0;
         dr_r <= 1'b0;
         en_r <= 1'b1;
         rd_r <= '0;
         busy_r <= 1'b0;
      end else if (ce) begin
         s_r <= s_nxt;
         hd_r <= hd_nxt;
         hv_r <= hv_nxt;
         len_r <= len_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         ckh_r <= ckh_nxt;
         crc_r <= crc_nxt;
         st_r <= st_nxt;
         ok_r <= ok_nxt;
         rv_r <= rv_nxt;
         to_r <= to_nxt;
         tmr_r <= tmr_nxt;
         dr_r <= dr_nxt;
         en_r <= en_in;
         rd_r <= rxm[rsp_rd_addr];
         busy_r <= (s_nxt != H_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (ce && req_wr_en) txm[req_wr_addr] <= req_wr_data;
      if (ce && rx_we) rxm[idx_r] <= link.d2h_data;
   end

   assign link.enable    = en_r;
   assign link.h2d_valid = hv_r;
   assign link.h2d_data  = hd_r;
   assign link.d2h_ready = dr_r;
   assign busy           = busy_r;
   assign rsp_valid      = rv_r;
   assign rsp_timeout    = to_r;
   assign rsp_crc_ok     = ok_r;
   assign rsp_op         = op_r;
   assign rsp_status     = st_r;
   assign rsp_len        = len_r;
   assign rsp_rd_data    = rd_r;
endmodule
`default_nettype wire

// ==== dv/rscf_link_monitor.sv ====
// link checker: framing, checksums, handshake hold and turn-taking on the byte link
// assumes one clock and that it watches the link joining the host end to the device end
`default_nettype none
module rscf_link_monitor (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // link
   input wire logic       enable,
   input wire logic [7:0] h2d_data,
   input wire logic       h2d_valid,
   input wire logic       h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic       d2h_valid,
   input wire logic       d2h_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0]  ri_r, di_r, re, de;
   logic [7:0]  rl_r, dl_r;
   logic [15:0] rc_r, dc_r;
   logic        pend_r, rt, dt, rlast, dlast;
   // own checksum code, so a shared slip in both ends cannot hide here
   function automatic logic [15:0] ck(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
      end
      return r;
   endfunction
   assign rt    = h2d_valid && h2d_ready;
   assign dt    = d2h_valid && d2h_ready;
   assign re    = {1'b0, rl_r} + 9'h004;
   assign de    = {1'b0, dl_r} + 9'h006;
   assign rlast = rt && ri_r == re;
   assign dlast = dt && di_r == de;
   // byte position, length and running checksum of each direction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ri_r   <= 9'h000;
         di_r   <= 9'h000;
         rl_r   <= 8'h00;
         dl_r   <= 8'h00;
         rc_r   <= 16'hffff;
         dc_r   <= 16'hffff;
         pend_r <= 1'b0;
      end else begin
         if (rt) begin
            ri_r <= rlast ? 9'h000 : ri_r + 9'h001;
            rl_r <= (ri_r == 9'h001) ? h2d_data : rl_r;
            rc_r <= (ri_r == 9'h000) ? 16'hffff : (ri_r < re - 9'h001) ? ck(rc_r, h2d_data) : rc_r;
         end
         if (dt) begin
            di_r <= dlast ? 9'h000 : di_r + 9'h001;
            dl_r <= (di_r == 9'h001) ? d2h_data : dl_r;
            dc_r <= (di_r == 9'h000) ? 16'hffff : (di_r < de - 9'h001) ? ck(dc_r, d2h_data) : dc_r;
         end
         pend_r <= enable && (rlast || (!dlast && pend_r));
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_req_hold; h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data); endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
   property p_rsp_hold; d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data); endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("response byte lost");
   property p_req_mark; rt && ri_r == 9'h000 |-> h2d_data == 8'hff; endproperty
   a_req_mark: assert property (p_req_mark) else $error("request marker wrong");
   property p_rsp_mark; dt && di_r == 9'h000 |-> d2h_data == 8'hff && !rlast; endproperty
   a_rsp_mark: assert property (p_rsp_mark) else $error("response marker wrong");
   property p_req_crc; rt && ri_r >= re - 9'h001 |-> h2d_data == (rlast ? rc_r[7:0] : rc_r[15:8]);
   endproperty
   a_req_crc: assert property (p_req_crc) else $error("bad request crc");
   property p_rsp_crc; dt && di_r >= de - 9'h001 |-> d2h_data == (dlast ? dc_r[7:0] : dc_r[15:8]);
   endproperty
   a_rsp_crc: assert property (p_rsp_crc) else $error("bad response crc");
   property p_slave; $rose(d2h_valid) |-> pend_r; endproperty
   a_slave: assert property (p_slave) else $error("device sent unasked");
   property p_one_out; rt |-> !pend_r; endproperty
   a_one_out: assert property (p_one_out) else $error("request while pending");
   property p_gate; !enable |=> !h2d_ready; endproperty
   a_gate: assert property (p_gate) else $error("ready while disabled");
endmodule
`default_nettype wire

// ==== dv/tb_reader_serial_command_framer.sv ====
// bench for the framer: host end and device end joined across the link interface
// assumes both ends keep their hand-over contract; the image rom is modelled here
`default_nettype none
module tb_reader_serial_command_framer import rscf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, en_in = 1'b1, rx_hold = 1'b0, bad = 1'b0;
   logic        req_valid = 1'b0, req_wr_en = 1'b0, boot_req = 1'b0, resp_valid = 1'b0;
   logic        resp_wr_en = 1'b0, busy, rsp_valid, rsp_crc_ok, app_run, boot_err, cmd_valid;
   logic        rsp_timeout;
   logic [7:0]  req_op = 8'h00, req_len = 8'h00, req_wr_addr = 8'h00, req_wr_data = 8'h00;
   logic [7:0]  rsp_rd_addr = 8'h00, cmd_rd_addr = 8'h00, resp_len = 8'h00, resp_wr_addr = 8'h00;
   logic [7:0]  resp_wr_data = 8'h00, rsp_op, rsp_len, rsp_rd_data, cmd_op, cmd_len, cmd_rd_data;
   logic [15:0] resp_status = 16'h0000, img_ok = 16'hffff, rsp_status, img_addr, img_crc;
   logic [23:0] tmo_cycles = 24'h00ffff;
   int          num_errors = 0, checks = 0, cycles = 0;
   assign img_crc = img_ok ^ {15'h0000, bad};
   rscf_link_if lk ();
   rscf_host rscf_host_inst (.clk, .rst_n, .ce, .link(lk), .en_in, .rx_hold, .tmo_cycles,
      .req_valid, .req_op, .req_len, .req_wr_en, .req_wr_addr, .req_wr_data, .busy, .rsp_valid,
      .rsp_timeout, .rsp_crc_ok, .rsp_op, .rsp_status, .rsp_len, .rsp_rd_addr, .rsp_rd_data);
   // short image keeps each boot scan to 16 cycles
   rscf_device #(.IMG_LAST(16'h000f)) rscf_device_inst (.clk, .rst_n, .ce, .link(lk),
      .img_addr, .img_data(img_addr[7:0] ^ 8'h3c), .img_crc, .boot_req, .app_run, .boot_err,
      .cmd_valid, .cmd_op, .cmd_len, .cmd_rd_addr, .cmd_rd_data, .resp_valid, .resp_status,
      .resp_len, .resp_wr_en, .resp_wr_addr, .resp_wr_data);
   rscf_link_monitor rscf_link_monitor_inst (.clk, .rst_n, .enable(lk.enable),
      .h2d_data(lk.h2d_data), .h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready),
      .d2h_data(lk.d2h_data), .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // a hang counts as one mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 50000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one command end to end; app low leaves the device to answer on its own
   task automatic xact(input logic [7:0] op, len, rl, logic [15:0] st, logic app, hold);
      int n;
      logic [7:0] el, er;
      el = (len > REQ_MAX) ? REQ_MAX : len;
      er = !app ? 8'h00 : ((rl > RSP_MAX) ? RSP_MAX : rl);
      for (n = 0; n < el; n++) begin
         req_wr_en = 1'b1;
         req_wr_addr = n[7:0];
         req_wr_data = op ^ n[7:0];
         @(negedge clk);
      end
      req_wr_en = 1'b0;
      req_op = op;
      req_len = len;
      req_valid = 1'b1;
      for (n = 0; n < 99 && busy !== 1'b1; n++) @(negedge clk);
      req_valid = 1'b0;
      if (app) begin
         for (n = 0; n < 999 && cmd_valid !== 1'b1; n++) @(negedge clk);
         chk(cmd_op, op);
         chk(cmd_len, el);
         for (n = 0; n < el; n++) begin
            cmd_rd_addr = n[7:0];
            @(negedge clk);
            chk(cmd_rd_data, op ^ n[7:0]);
         end
         for (n = 0; n < er; n++) begin
            resp_wr_en = 1'b1;
            resp_wr_addr = n[7:0];
            resp_wr_data = op + n[7:0];
            @(negedge clk);
         end
         resp_wr_en = 1'b0;
         resp_status = st;
         resp_len = rl;
         resp_valid = 1'b1;
         @(negedge clk);
         resp_valid = 1'b0;
      end
      // stalling the reader side exercises the response buffer
      for (n = 0; n < 2999 && rsp_valid !== 1'b1; n++) begin
         rx_hold = hold & n[1];
         @(negedge clk);
      end
      rx_hold = 1'b0;
      chk(rsp_op, op);
      chk(rsp_status, st);
      chk(rsp_len, er);
      chk(rsp_crc_ok, 1'b1);
      for (n = 0; n < er; n++) begin
         rsp_rd_addr = n[7:0];
         @(negedge clk);
         chk(rsp_rd_data, op + n[7:0]);
      end
   endtask
   task automatic reboot(input logic b);
      int n;
      bad = b;
      ce = 1'b0;
      en_in = 1'b0;
      repeat (2) @(negedge clk);
      chk(lk.enable, 1'b1);
      ce = 1'b1;
      repeat (4) @(negedge clk);
      chk(lk.h2d_data, 8'h00);
      en_in = 1'b1;
      for (n = 0; n < 99 && (b ? boot_err : app_run) !== 1'b1; n++) @(negedge clk);
      chk({app_run, boot_err}, {!b, b});
   endtask
   initial begin
      int n;
      for (n = 0; n < 16; n++) img_ok = rscf_link_monitor_inst.ck(img_ok, n[7:0] ^ 8'h3c);
      repeat (3) @(negedge clk);
      chk(lk.enable, 1'b1);
      rst_n = 1'b1;
      @(negedge clk);
      chk(lk.h2d_ready, 1'b0);
      for (n = 0; n < 99 && app_run !== 1'b1; n++) @(negedge clk);
      chk({app_run, boot_err}, 2'b10);
      xact(8'h01, 8'h00, 8'h00, ST_OK, 1'b1, 1'b0);
      xact(8'h02, 8'hfa, 8'hf8, 16'h1234, 1'b1, 1'b1);
      xact(8'h03, 8'hff, 8'hff, ST_OK, 1'b1, 1'b0);
      for (n = 0; n < 4; n++) begin
         xact(8'h30 + n[7:0], n[7:0] * 8'h05, n[7:0], 16'h0007, 1'b1, n[0]);
      end
      boot_req = 1'b1;
      for (n = 0; n < 99 && app_run !== 1'b0; n++) @(negedge clk);
      chk(app_run, 1'b0);
      xact(8'h40, 8'h01, 8'h02, ST_OK, 1'b1, 1'b0);
      boot_req = 1'b0;
      for (n = 0; n < 99 && app_run !== 1'b1; n++) @(negedge clk);
      chk(app_run, 1'b1);
      reboot(1'b1);
      xact(8'h44, 8'h02, 8'h00, ST_BOOT_ERR, 1'b0, 1'b0);
      reboot(1'b0);
      xact(8'h45, 8'h03, 8'h01, ST_OK, 1'b1, 1'b1);
      tmo_cycles = 24'h000020;
      req_valid = 1'b1;
      for (n = 0; n < 99 && busy !== 1'b1; n++) @(negedge clk);
      req_valid = 1'b0;
      for (n = 0; n < 99 && rsp_timeout !== 1'b1; n++) @(negedge clk);
      chk(rsp_timeout, 1'b1);
      reboot(1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
